// file: hw/ypk_pkg.sv
// Package for the 4:2:2 pixel packer: constants, format codes and stream carriers.
package ypk_pkg;

    // Sample width of each colour input and each output byte.
    localparam int COLOR_W = 8;

    // Weights in 1/256 units, rounded to nearest; all sums of a row are exact.
    localparam int FRAC_BITS = 8;
    localparam logic signed [9:0] W_Y_R  = 10'sd77;   // 0.30 scaled.
    localparam logic signed [9:0] W_Y_G  = 10'sd151;  // 0.59 scaled.
    localparam logic signed [9:0] W_Y_B  = 10'sd28;   // 0.11 scaled.
    localparam logic signed [9:0] W_CB_R = -10'sd44;  // -0.17 scaled.
    localparam logic signed [9:0] W_CB_G = -10'sd84;  // -0.33 scaled.
    localparam logic signed [9:0] W_CB_B = 10'sd128;  // 0.50 scaled.
    localparam logic signed [9:0] W_CR_R = 10'sd128;  // 0.50 scaled.
    localparam logic signed [9:0] W_CR_G = -10'sd105; // -0.41 scaled.
    localparam logic signed [9:0] W_CR_B = -10'sd23;  // -0.09 scaled.
    localparam logic signed [19:0] ROUND_HALF = 20'sd128; // Half an LSB.

    // Saturation limits and chroma offset.
    localparam logic signed [19:0] LUMA_MIN   = 20'sd0;
    localparam logic signed [19:0] LUMA_MAX   = 20'sd255;
    localparam logic signed [19:0] CHROMA_MIN = -20'sd128;
    localparam logic signed [19:0] CHROMA_MAX = 20'sd127;
    localparam logic [7:0]         CHROMA_OFFSET = 8'h80;

    // Bytes per pixel-pair group.
    localparam int GROUP_BYTES = 4;

    // Byte order selection.
    typedef enum logic {
        standard_order_chroma_first_format = 1'b0,
        luma_first_order_format            = 1'b1
    } ypk_order_e;

    // Incoming RGB pixel with frame markers.
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic       sof;  // First pixel of a frame.
        logic       eof;  // Last pixel of a frame.
    } ypk_pix_s;

    // Outgoing byte with frame markers.
    typedef struct packed {
        logic [7:0] data;
        logic       sof;
        logic       eof;
    } ypk_byte_s;

endpackage

// file: hw/ypk_packer.sv
// Converts RGB pixels to luma/chroma and packs pixel pairs into a 4:2:2 byte stream.
`timescale 1ns/1ns
`default_nettype none
module ypk_packer
    import ypk_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       order_sel,   // Requested byte order, 1 = luma first.
    input  wire logic       pix_valid,
    output logic            pix_ready,
    input  wire ypk_pix_s   pix_in,
    output logic            byte_valid,
    input  wire logic       byte_ready,
    output ypk_byte_s       byte_out
);

    // Packer states, one-hot.
    typedef enum logic [2:0] {
        ST_EVEN = 3'b001,  // Waiting for the even pixel of a pair.
        ST_ODD  = 3'b010,  // Waiting for the odd pixel of a pair.
        ST_SEND = 3'b100   // Shifting out the four bytes of a group.
    } ypk_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Colour conversion, purely combinational on the incoming pixel.

    logic signed [19:0] y_acc;   // Luma before rounding.
    logic signed [19:0] cb_acc;  // Blue difference before rounding.
    logic signed [19:0] cr_acc;  // Red difference before rounding.
    logic signed [19:0] y_sh;    // Rounded luma.
    logic signed [19:0] cb_sh;   // Rounded blue difference.
    logic signed [19:0] cr_sh;   // Rounded red difference.
    logic [7:0]         y_byte;  // Encoded luma.
    logic [7:0]         cb_byte; // Encoded blue difference.
    logic [7:0]         cr_byte; // Encoded red difference.
    logic signed [19:0] y_cl;    // Saturated luma.
    logic signed [19:0] cb_cl;   // Saturated blue difference.
    logic signed [19:0] cr_cl;   // Saturated red difference.

    // Clamp a signed value into a range; keeps codes from wrapping.
    function automatic logic signed [19:0] clamp(input logic signed [19:0] v,
                                                 input logic signed [19:0] lo,
                                                 input logic signed [19:0] hi);
        logic signed [19:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // Weighted sums, rounded with an arithmetic shift, then saturated and encoded.
    always_comb begin
        y_acc  = W_Y_R * $signed({12'h000, pix_in.red}) + W_Y_G * $signed({12'h000, pix_in.green})
               + W_Y_B * $signed({12'h000, pix_in.blue});
        cb_acc = W_CB_R * $signed({12'h000, pix_in.red})
               + W_CB_G * $signed({12'h000, pix_in.green})
               + W_CB_B * $signed({12'h000, pix_in.blue});
        cr_acc = W_CR_R * $signed({12'h000, pix_in.red})
               + W_CR_G * $signed({12'h000, pix_in.green})
               + W_CR_B * $signed({12'h000, pix_in.blue});
        y_sh   = (y_acc + ROUND_HALF) >>> FRAC_BITS;
        cb_sh  = (cb_acc + ROUND_HALF) >>> FRAC_BITS;
        cr_sh  = (cr_acc + ROUND_HALF) >>> FRAC_BITS;
        // Saturate before encoding, so that no code can wrap around.
        y_cl    = clamp(y_sh, LUMA_MIN, LUMA_MAX);
        cb_cl   = clamp(cb_sh, CHROMA_MIN, CHROMA_MAX);
        cr_cl   = clamp(cr_sh, CHROMA_MIN, CHROMA_MAX);
        // Luma travels as a plain unsigned level.
        y_byte  = y_cl[7:0];
        // Chroma is offset after saturation, so -128 maps to 0x00.
        cb_byte = cb_cl[7:0] + CHROMA_OFFSET;
        cr_byte = cr_cl[7:0] + CHROMA_OFFSET;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pair capture and byte sequencing.

    ypk_state_e state;       // Current packer state.
    ypk_state_e next_state;
    ypk_order_e frame_order; // Byte order in force for the current frame.
    ypk_order_e next_frame_order;
    logic [7:0] hold_y0;     // Luma of the even pixel.
    logic [7:0] next_hold_y0;
    logic [7:0] hold_cb;     // Chroma of the even pixel; odd pixel chroma is dropped.
    logic [7:0] next_hold_cb;
    logic [7:0] hold_cr;
    logic [7:0] next_hold_cr;
    logic [7:0] hold_y1;     // Luma of the odd pixel.
    logic [7:0] next_hold_y1;
    logic       hold_sof;    // Group opens a frame.
    logic       next_hold_sof;
    logic       hold_eof;    // Group closes a frame.
    logic       next_hold_eof;
    logic [1:0] byte_idx;    // Position within the four-byte group.
    logic [1:0] next_byte_idx;
    logic       next_pix_ready;
    logic       next_byte_valid;
    ypk_byte_s  next_byte_out;
    logic       take;        // A pixel is accepted this cycle.
    logic       group_done;  // The last byte of a group is accepted.
    logic [7:0] sel_byte;    // Byte chosen for the next output slot.
    logic [1:0] sel_idx;     // Slot whose byte goes out next.

    assign take       = pix_valid && pix_ready;
    assign group_done = byte_valid && byte_ready && (byte_idx == 2'(GROUP_BYTES - 1));

    // Picks the byte for a slot; only the order differs between formats.
    function automatic logic [7:0] pick(input ypk_order_e ord, input logic [1:0] idx,
                                        input logic [7:0] y0, input logic [7:0] cb,
                                        input logic [7:0] cr, input logic [7:0] y1);
        logic [7:0] b;
        b = y0;
        if (ord == standard_order_chroma_first_format) begin
            case (idx)
                2'h0:    b = cb;
                2'h1:    b = y0;
                2'h2:    b = cr;
                default: b = y1;
            endcase
        end else begin
            case (idx)
                2'h0:    b = y0;
                2'h1:    b = cb;
                2'h2:    b = y1;
                default: b = cr;
            endcase
        end
        return b;
    endfunction

    // Next-state logic for capture, order latching and output.
    always_comb begin
        next_state       = state;
        next_frame_order = frame_order;
        next_hold_y0     = hold_y0;
        next_hold_cb     = hold_cb;
        next_hold_cr     = hold_cr;
        next_hold_y1     = hold_y1;
        next_hold_sof    = hold_sof;
        next_hold_eof    = hold_eof;
        next_byte_idx    = byte_idx;
        next_pix_ready   = pix_ready;
        next_byte_valid  = byte_valid;
        next_byte_out    = byte_out;
        sel_idx          = 2'h0;
        sel_byte         = 8'h00;
        case (state)
            ST_EVEN: begin
                // Input is open whenever no pair is held; after reset it opens on the first clock edge.
                next_pix_ready = 1'b1;
                if (take) begin
                    // Order is sampled only on a frame's first pixel.
                    if (pix_in.sof) begin
                        next_frame_order = ypk_order_e'(order_sel);
                    end
                    next_hold_y0  = y_byte;
                    next_hold_cb  = cb_byte;
                    next_hold_cr  = cr_byte;
                    next_hold_sof = pix_in.sof;
                    next_state    = ST_ODD;
                end
            end
            ST_ODD: begin
                if (take) begin
                    // Odd pixel adds only its luma; the group is then complete.
                    next_hold_y1    = y_byte;
                    next_hold_eof   = pix_in.eof;
                    next_pix_ready  = 1'b0;
                    next_byte_idx   = 2'h0;
                    next_byte_valid = 1'b1;
                    next_byte_out.data = pick(frame_order, 2'h0, hold_y0, hold_cb, hold_cr,
                                              y_byte);
                    next_byte_out.sof  = hold_sof;
                    next_byte_out.eof  = 1'b0;
                    next_state      = ST_SEND;
                end
            end
            ST_SEND: begin
                if (byte_valid && byte_ready) begin
                    if (group_done) begin
                        // Input reopens only after the whole group has left.
                        next_byte_valid = 1'b0;
                        next_pix_ready  = 1'b1;
                        next_state      = ST_EVEN;
                    end else begin
                        sel_idx  = byte_idx + 2'h1;
                        sel_byte = pick(frame_order, sel_idx, hold_y0, hold_cb, hold_cr,
                                        hold_y1);
                        next_byte_idx      = sel_idx;
                        next_byte_out.data = sel_byte;
                        next_byte_out.sof  = 1'b0;
                        next_byte_out.eof  = hold_eof && (sel_idx == 2'(GROUP_BYTES - 1));
                    end
                end
            end
            default: begin
                next_state     = ST_EVEN;
                next_pix_ready = 1'b1;
                next_byte_valid = 1'b0;
            end
        endcase
    end

    // Registers for the packer; all outputs come from here.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= ST_EVEN;
            frame_order <= standard_order_chroma_first_format;
            hold_y0     <= 8'h00;
            hold_cb     <= 8'h00;
            hold_cr     <= 8'h00;
            hold_y1     <= 8'h00;
            hold_sof    <= 1'b0;
            hold_eof    <= 1'b0;
            byte_idx    <= 2'h0;
            pix_ready   <= 1'b0;
            byte_valid  <= 1'b0;
            byte_out    <= '0;
        end else begin
            state       <= next_state;
            frame_order <= next_frame_order;
            hold_y0     <= next_hold_y0;
            hold_cb     <= next_hold_cb;
            hold_cr     <= next_hold_cr;
            hold_y1     <= next_hold_y1;
            hold_sof    <= next_hold_sof;
            hold_eof    <= next_hold_eof;
            byte_idx    <= next_byte_idx;
            pix_ready   <= next_pix_ready;
            byte_valid  <= next_byte_valid;
            byte_out    <= next_byte_out;
        end
    end

endmodule
`default_nettype wire

// file: verif/ypk_packer_properties.sv
// Checker of the packer's pixel handshake and byte group framing.
`timescale 1ns/1ns
`default_nettype none
module ypk_packer_properties
    import ypk_pkg::*;
(
    input wire logic      core_clk,
    input wire logic      rst_n,
    input wire logic      order_sel,
    input wire logic      pix_valid,
    input wire logic      pix_ready,
    input wire ypk_pix_s  pix_in,
    input wire logic      byte_valid,
    input wire logic      byte_ready,
    input wire ypk_byte_s byte_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic       odd;  // High once the even pixel of a pair is taken.
    logic [1:0] bcnt; // Bytes of the current group already accepted.
    wire logic  take = pix_valid && pix_ready;
    wire logic  send = byte_valid && byte_ready;
    // Track pair parity and group position from the handshakes alone.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            odd  <= 1'b0;
            bcnt <= 2'h0;
        end else begin
            odd  <= odd ^ take;
            bcnt <= bcnt + 2'(send);
        end
    end
    sequence pair_end;
        take && odd;
    endsequence
    sequence group_end;
        send && bcnt == 2'h3;
    endsequence
    sequence frame_open;
        (take && !odd && pix_in.sof) ##1 (take && odd);
    endsequence
    sof_first_a: assert property (frame_open |=> byte_valid && byte_out.sof)
        else $error("frame start missing on first byte");
    answer_after_pair_a: assert property (pair_end |=> byte_valid && bcnt == 2'h0)
        else $error("no group after the odd pixel");
    group_len_a: assert property (group_end |=> !byte_valid && pix_ready)
        else $error("group did not end after four bytes");
    next_byte_a: assert property (send && bcnt != 2'h3 |=> byte_valid)
        else $error("group broke off early");
    sof_place_a: assert property (byte_valid && byte_out.sof |-> bcnt == 2'h0)
        else $error("frame start not on first byte");
    eof_place_a: assert property (byte_valid && byte_out.eof |-> bcnt == 2'h3)
        else $error("frame end not on last byte");
    byte_hold_a: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_out))
        else $error("byte changed before acceptance");
    busy_block_a: assert property (byte_valid |-> !pix_ready)
        else $error("pixel accepted during a group");
    valid_cause_a: assert property ($rose(byte_valid) |-> $past(take) && $past(odd))
        else $error("group started without a pair");
endmodule
bind ypk_packer ypk_packer_properties u_props (.core_clk(core_clk), .rst_n(rst_n),
    .order_sel(order_sel), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_in(pix_in),
    .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_out(byte_out));
`default_nettype wire

// file: verif/ypk_byte_sink.sv
// Host buffer model: accepts bytes, optionally stalling every other cycle.
`timescale 1ns/1ns
`default_nettype none
module ypk_byte_sink
    import ypk_pkg::*;
(
    input wire logic      core_clk,
    input wire logic      rst_n,
    input wire logic      slow,
    input wire logic      byte_valid,
    input wire ypk_byte_s byte_out,
    output logic          byte_ready
);
    ypk_byte_s got[$]; // Bytes in arrival order, drained by the bench.
    initial byte_ready = 1'b0;
    // A slow buffer toggles ready so each byte that follows an accepted one meets a stall.
    always @(negedge core_clk) byte_ready <= rst_n && (slow ? !byte_ready : 1'b1);
    // Store each byte at the edge that hands it over.
    always @(posedge core_clk) begin
        if (rst_n && byte_valid && byte_ready) got.push_back(byte_out);
    end
endmodule
`default_nettype wire

// file: verif/test_yuv422_pixel_packer.sv
// Self-checking bench for the 4:2:2 pixel packer.
`timescale 1ns/1ns
`default_nettype none
module test_yuv422_pixel_packer;
    import ypk_pkg::*;
    logic      core_clk, rst_n, order_sel, pix_valid, pix_ready, byte_valid, byte_ready, slow;
    ypk_pix_s  pix_in;
    ypk_byte_s byte_out;
    int        mismatches = 0;
    int        comparisons = 0;
    int        cycles = 0;
    // White, black, pure blue (chroma saturates), pure red on the odd slot.
    logic [7:0] pr[4] = '{8'hff, 8'h00, 8'h00, 8'hff};
    logic [7:0] pg[4] = '{8'hff, 8'h00, 8'h00, 8'h00};
    logic [7:0] pb[4] = '{8'hff, 8'h00, 8'hff, 8'h00};
    ypk_packer u_dut (.core_clk(core_clk), .rst_n(rst_n), .order_sel(order_sel),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_in(pix_in),
        .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_out(byte_out));
    ypk_byte_sink u_sink (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
        .byte_valid(byte_valid), .byte_out(byte_out), .byte_ready(byte_ready));
    always #50 core_clk = ~core_clk;
    // A hang is cut short well beyond the hundred or so cycles the run needs.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp_byte(input ypk_byte_s got, input ypk_byte_s exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Fixed-point conversion with clamping; chroma gets the 0x80 offset.
    function automatic logic [7:0] conv(int wr, int wg, int wb, int i, bit chroma);
        int s;
        // Samples are cast to int so that negative sums stay signed.
        s = (wr * int'(pr[i]) + wg * int'(pg[i]) + wb * int'(pb[i]) + 128) >>> 8;
        if (chroma) return 8'(((s < -128) ? -128 : (s > 127) ? 127 : s) + 128);
        return 8'((s < 0) ? 0 : (s > 255) ? 255 : s);
    endfunction
    // Sends one four-pixel frame, optionally flipping the order request mid-frame.
    task automatic send_frame(input logic ord, input bit flip, input logic slw);
        logic [31:0] grp;
        ypk_byte_s   exp;
        slow = slw;
        order_sel = ord;
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            if (flip && i == 2) order_sel = !ord;
            pix_valid = 1'b1;
            pix_in = {pr[i], pg[i], pb[i], i == 0, i == 3};
            while (pix_ready !== 1'b1) @(negedge core_clk);
            if (i % 2 == 1) begin
                @(negedge core_clk);
                cmp_flag({pix_ready, byte_valid}, 2'b01);
            end
        end
        @(negedge core_clk);
        pix_valid = 1'b0;
        while (u_sink.got.size() < 8) @(negedge core_clk);
        for (int k = 0; k < 8; k++) begin
            grp = {conv(W_Y_R, W_Y_G, W_Y_B, k / 2 * 0 + (k / 4) * 2, 0),
                   conv(W_CB_R, W_CB_G, W_CB_B, (k / 4) * 2, 1),
                   conv(W_Y_R, W_Y_G, W_Y_B, (k / 4) * 2 + 1, 0),
                   conv(W_CR_R, W_CR_G, W_CR_B, (k / 4) * 2, 1)};
            if (!ord) grp = {grp[23:16], grp[31:24], grp[7:0], grp[15:8]};
            exp = {grp[31 - 8 * (k % 4) -: 8], k == 0, k == 7};
            cmp_byte(u_sink.got[k], exp);
        end
        u_sink.got.delete();
    endtask
    task automatic t_std();
        send_frame(1'b0, 1'b0, 1'b0);
    endtask
    task automatic t_latch();
        send_frame(1'b0, 1'b1, 1'b1);
    endtask
    task automatic t_yuyv();
        send_frame(1'b1, 1'b0, 1'b1);
    endtask
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        order_sel = 1'b0;
        pix_valid = 1'b0;
        pix_in = '0;
        slow = 1'b0;
        repeat (20) @(negedge core_clk);
        cmp_byte(byte_out, '0);
        cmp_flag({pix_ready, byte_valid}, 2'b00);
        rst_n = 1'b1;
        t_std();
        t_latch();
        t_yuyv();
        finish_test();
    end
endmodule
`default_nettype wire
